// >>> seq_pkg.sv
/*
  Shared constants and types of the operation data sequencer: table layout,
  field positions, values after reset, successor codes, timing.
  Assumes a single 125 MHz clock and a word-addressed register port.
*/
package seq_pkg;

  // table word address = {entry index, field}
  localparam int IDX_W = 8;
  localparam int FLD_W = 2;
  localparam int TAB_AW = IDX_W + FLD_W;
  localparam int REG_AW = 11;
  localparam logic [1:0] FLD_POS = 2'h0;
  localparam logic [1:0] FLD_CFG = 2'h1;
  localparam logic [1:0] FLD_OFS = 2'h2;
  localparam logic [1:0] FLD_DLY = 2'h3;

  // config word layout
  localparam int CFG_INC = 0;
  localparam int CFG_LINK = 1;
  localparam int CFG_END = 3;
  localparam int CFG_NEXT = 4;
  localparam int CFG_CNT = 13;
  localparam int OFS_W = 23;

  // values after reset: successor -1, everything else zero
  localparam logic [31:0] CFG_RST = 32'h00001ff0;
  localparam logic [31:0] WORD_RST = 32'h00000000;

  localparam logic [8:0] NEXT_STOP = 9'h100;
  localparam logic [8:0] NEXT_SKIP = 9'h1fe;
  localparam logic [8:0] NEXT_FOLLOW = 9'h1ff;
  localparam logic [7:0] LOOP_MIN = 8'h02;

  localparam logic [10:0] REG_STATUS = 11'h400;
  localparam logic [10:0] REG_ACCUM = 11'h401;

  localparam int CLK_NS = 8;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_NS;

  typedef enum logic [1:0] {LINK_NONE, LINK_STEP, LINK_TIMED, LINK_FLY} link_t;
  typedef enum logic [2:0] {S_IDLE, S_FETCH, S_LAUNCH, S_RUN, S_STEP, S_DELAY} state_t;

endpackage

// >>> mem_port_if.sv
/*
  Two-read, one-write port bundle between the sequencer and its table store.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
interface mem_port_if #(parameter int ADDR_W = 10, parameter int DATA_W = 32);
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [ADDR_W-1:0] a_addr;
  logic [DATA_W-1:0] a_data;
  logic [ADDR_W-1:0] b_addr;
  logic [DATA_W-1:0] b_data;
  modport store (input wr_en, wr_addr, wr_data, a_addr, b_addr, output a_data, b_data);
  modport user (output wr_en, wr_addr, wr_data, a_addr, b_addr, input a_data, b_data);
endinterface

// >>> entry_store.sv
/*
  Operation data table: one write port, two registered read ports.
  Assumes the user masks never-written words; cells have no reset.
*/
`timescale 1ns/1ps
module entry_store #(
  parameter int ADDR_W = 10,
  parameter int DATA_W = 32
) (
  input wire logic ref_clk,
  mem_port_if.store port
);
  logic [DATA_W-1:0] cells [2**ADDR_W];

  if (ADDR_W < 1 || DATA_W < 1) begin : g_bad
    $error("entry_store: bad geometry");
  end

  always_ff @(posedge ref_clk) begin
    if (port.wr_en) begin
      cells[port.wr_addr] <= port.wr_data;
    end
    port.a_data <= cells[port.a_addr];
    port.b_data <= cells[port.b_addr];
  end
endmodule

// >>> delay_timer.sv
/*
  Millisecond countdown for timed chaining: a divider makes a 1 ms enable.
  Assumes load is a one-cycle pulse; a load while running restarts it.
*/
`timescale 1ns/1ps
module delay_timer #(
  parameter int TICK_CYCLES = seq_pkg::MS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [15:0] ms_count,
  output logic expired
);
  localparam int DIV_W = $clog2(TICK_CYCLES + 1);
  logic [DIV_W-1:0] div;
  logic [15:0] left;
  logic running;
  logic tick;

  if (TICK_CYCLES < 1) begin : g_bad
    $error("delay_timer: TICK_CYCLES below one");
  end

  assign tick = running && (div == DIV_W'(TICK_CYCLES - 1));

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      running <= 1'b0;
      div <= '0;
      left <= 16'h0000;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (load) begin
        running <= 1'b1;
        div <= '0;
        left <= ms_count;
      end else if (running) begin
        if (left == 16'h0000) begin
          running <= 1'b0;
          expired <= 1'b1;
        end else if (tick) begin
          div <= '0;
          left <= left - 16'h0001;
        end else begin
          div <= div + DIV_W'(1);
        end
      end
    end
  end
endmodule

// >>> operation_data_loop_sequencer.sv
/*
  Operation data sequencer: steps through stored entries, runs counted loops
  with a per-pass position offset and endless pointer loops.
  Assumes an external profile generator that takes motion_start with target
  and reports motion_done once the target is reached; host pins are async.
*/
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module operation_data_loop_sequencer #(
  parameter int TICK_CYCLES = seq_pkg::MS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [10:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic start_input,
  input wire logic stop_input,
  input wire logic sequence_step_input,
  input wire logic [7:0] select_index,
  input wire logic event_jump,
  input wire logic [7:0] event_index,
  input wire logic motion_done,
  output logic motion_start,
  output logic motion_stop,
  output logic motion_blend,
  output logic motion_incremental,
  output logic [31:0] motion_target,
  output logic sequence_busy_output,
  output logic ready_output,
  output logic [7:0] current_index
);
  localparam int PINS = 11;

  seq_pkg::state_t state, next_state;
  logic [PINS-1:0] pin_raw, pin_level, pin_rise;
  logic [2:0] pin_sync [PINS];
  logic [1023:0] field_valid;
  logic b_val_q;
  logic rd_q, rd_tab, rd_val;
  logic [1:0] rd_fld;
  logic [31:0] rd_word;
  logic [2:0] fcnt;
  logic [7:0] idx;
  logic [31:0] e_pos, e_cfg, e_dly;
  logic signed [seq_pkg::OFS_W-1:0] e_ofs;
  seq_pkg::link_t e_link;
  logic e_end, e_inc;
  logic [8:0] e_next;
  logic [7:0] e_cnt;
  logic loop_active;
  logic [7:0] loop_start, loop_total, pass;
  logic signed [seq_pkg::OFS_W-1:0] loop_ofs;
  logic signed [31:0] accum;
  logic blend_next;
  logic start_req, stop_lvl, step_rise, done_now;
  logic loop_wrap, halt, jump_ok, timer_load, timer_expired;
  logic [8:0] succ;

  mem_port_if #(.ADDR_W(seq_pkg::TAB_AW), .DATA_W(32)) mem ();

  entry_store #(.ADDR_W(seq_pkg::TAB_AW), .DATA_W(32)) u_store (
    .ref_clk(ref_clk),
    .port(mem.store)
  );

  delay_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(timer_load),
    .ms_count(e_dly[15:0]),
    .expired(timer_expired)
  );

  function automatic logic [31:0] field_default(input logic [1:0] fld);
    field_default = (fld == seq_pkg::FLD_CFG) ? seq_pkg::CFG_RST : seq_pkg::WORD_RST;
  endfunction

  // returns {stop, index}; index past 255 also stops
  function automatic logic [8:0] successor(input logic [7:0] cur, input logic [8:0] code);
    if (code == seq_pkg::NEXT_FOLLOW) begin
      successor = {1'b0, cur} + 9'h001;
    end else if (code == seq_pkg::NEXT_SKIP) begin
      successor = {1'b0, cur} + 9'h002;
    end else if (!code[8]) begin
      successor = {1'b0, code[7:0]};
    end else begin
      successor = {1'b1, cur};
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // host pins: three flops, a change counts once stages two and three agree

  assign pin_raw = {select_index, sequence_step_input, stop_input, start_input};

  for (genvar i = 0; i < PINS; i++) begin : g_pin
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        pin_sync[i] <= 3'h0;
        pin_level[i] <= 1'b0;
        pin_rise[i] <= 1'b0;
      end else begin
        pin_sync[i] <= {pin_sync[i][1:0], pin_raw[i]};
        pin_rise[i] <= 1'b0;
        if (pin_sync[i][1] == pin_sync[i][2]) begin
          pin_level[i] <= pin_sync[i][2];
          pin_rise[i] <= pin_sync[i][2] & ~pin_level[i];
        end
      end
    end
  end

  assign stop_lvl = pin_level[1];
  assign step_rise = pin_rise[2];
  // step with busy off runs the selected entry, like start
  assign start_req = pin_rise[0] | step_rise;

  //////////////////////////////////////////////////////////////////////////////
  // register port

  assign mem.wr_en = reg_wr && !reg_addr[10];
  assign mem.wr_addr = reg_addr[9:0];
  assign mem.wr_data = reg_wdata;
  assign mem.a_addr = reg_addr[9:0];
  assign mem.b_addr = {idx, fcnt[1:0]};

  // never-written words read as their values after reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      field_valid <= '0;
    end else if (mem.wr_en) begin
      field_valid[reg_addr[9:0]] <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_q <= 1'b0;
      rd_tab <= 1'b0;
      rd_val <= 1'b0;
      rd_fld <= 2'h0;
      rd_word <= 32'h00000000;
    end else begin
      rd_q <= reg_rd;
      rd_tab <= !reg_addr[10];
      rd_val <= field_valid[reg_addr[9:0]];
      rd_fld <= reg_addr[1:0];
      case (reg_addr)
        seq_pkg::REG_STATUS: rd_word <= {4'h0, state, loop_active, loop_total, pass, idx};
        seq_pkg::REG_ACCUM: rd_word <= accum;
        default: rd_word <= 32'h00000000;
      endcase
    end
  end

  always_comb begin
    reg_rdata = 32'h00000000;
    if (rd_q) begin
      reg_rdata = rd_tab ? (rd_val ? mem.a_data : field_default(rd_fld)) : rd_word;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // entry fetch: four words, one cycle read latency

  assign e_link = seq_pkg::link_t'(e_cfg[seq_pkg::CFG_LINK +: 2]);
  assign e_end = e_cfg[seq_pkg::CFG_END];
  assign e_inc = e_cfg[seq_pkg::CFG_INC];
  assign e_next = e_cfg[seq_pkg::CFG_NEXT +: 9];
  assign e_cnt = e_cfg[seq_pkg::CFG_CNT +: 8];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fcnt <= 3'h0;
      b_val_q <= 1'b0;
      e_pos <= seq_pkg::WORD_RST;
      e_cfg <= seq_pkg::CFG_RST;
      e_ofs <= '0;
      e_dly <= seq_pkg::WORD_RST;
    end else begin
      b_val_q <= field_valid[mem.b_addr];
      fcnt <= (state == seq_pkg::S_FETCH) ? fcnt + 3'h1 : 3'h0;
      if (state == seq_pkg::S_FETCH && fcnt != 3'h0) begin
        case (fcnt[1:0] - 2'h1)
          seq_pkg::FLD_POS: e_pos <= b_val_q ? mem.b_data : field_default(seq_pkg::FLD_POS);
          seq_pkg::FLD_CFG: e_cfg <= b_val_q ? mem.b_data : field_default(seq_pkg::FLD_CFG);
          seq_pkg::FLD_OFS: e_ofs <= b_val_q ? mem.b_data[seq_pkg::OFS_W-1:0] : '0;
          default: e_dly <= b_val_q ? mem.b_data : field_default(seq_pkg::FLD_DLY);
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // chaining decision at the end of an entry

  assign done_now = (state == seq_pkg::S_RUN) && motion_done;
  assign loop_wrap = loop_active && e_end && (pass < loop_total);
  // at a loop end, pointer successors take effect only when no pass is left to run
  assign succ = loop_wrap ? {1'b0, loop_start} : successor(idx, e_next);
  assign halt = (e_link == seq_pkg::LINK_NONE) || (!loop_wrap && succ[8]);
  assign jump_ok = event_jump && (state == seq_pkg::S_RUN || state == seq_pkg::S_STEP
                   || state == seq_pkg::S_DELAY);
  assign timer_load = done_now && !halt && e_link == seq_pkg::LINK_TIMED;

  always_comb begin
    next_state = state;
    case (state)
      seq_pkg::S_IDLE: begin
        if (start_req && !stop_lvl) begin
          next_state = seq_pkg::S_FETCH;
        end
      end
      seq_pkg::S_FETCH: begin
        if (fcnt == 3'h4) begin
          next_state = seq_pkg::S_LAUNCH;
        end
      end
      seq_pkg::S_LAUNCH: next_state = seq_pkg::S_RUN;
      seq_pkg::S_RUN: begin
        if (motion_done) begin
          if (halt) begin
            next_state = seq_pkg::S_IDLE;
          end else begin
            case (e_link)
              seq_pkg::LINK_STEP: next_state = seq_pkg::S_STEP;
              seq_pkg::LINK_TIMED: next_state = seq_pkg::S_DELAY;
              default: next_state = seq_pkg::S_FETCH;
            endcase
          end
        end
      end
      seq_pkg::S_STEP: begin
        if (step_rise) begin
          next_state = seq_pkg::S_FETCH;
        end
      end
      seq_pkg::S_DELAY: begin
        if (timer_expired) begin
          next_state = seq_pkg::S_FETCH;
        end
      end
      default: next_state = seq_pkg::S_IDLE;
    endcase
    if (jump_ok) begin
      next_state = seq_pkg::S_FETCH;
    end
    if (stop_lvl && state != seq_pkg::S_IDLE) begin
      next_state = seq_pkg::S_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= seq_pkg::S_IDLE;
      sequence_busy_output <= 1'b0;
      ready_output <= 1'b1;
    end else begin
      state <= next_state;
      sequence_busy_output <= next_state != seq_pkg::S_IDLE;
      ready_output <= next_state == seq_pkg::S_IDLE || next_state == seq_pkg::S_STEP;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      idx <= 8'h00;
      blend_next <= 1'b0;
    end else if (state == seq_pkg::S_IDLE && next_state == seq_pkg::S_FETCH) begin
      idx <= pin_level[10:3];
      blend_next <= 1'b0;
    end else if (jump_ok) begin
      idx <= event_index;
      blend_next <= 1'b0;
    end else if (done_now && !halt) begin
      idx <= succ[7:0];
      blend_next <= e_link == seq_pkg::LINK_FLY;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // counted loop state

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      loop_active <= 1'b0;
      loop_start <= 8'h00;
      loop_total <= 8'h00;
      pass <= 8'h00;
      loop_ofs <= '0;
      accum <= 32'sh00000000;
    end else if (next_state == seq_pkg::S_IDLE || jump_ok) begin
      loop_active <= 1'b0;
    end else if (state == seq_pkg::S_LAUNCH && !loop_active && e_cnt >= seq_pkg::LOOP_MIN) begin
      // count 0 means no loop, count 1 is refused the same way
      loop_active <= 1'b1;
      loop_start <= idx;
      loop_total <= e_cnt;
      pass <= 8'h01;
      loop_ofs <= e_ofs;
      accum <= 32'sh00000000;
    end else if (done_now && loop_active && e_end) begin
      if (loop_wrap) begin
        pass <= pass + 8'h01;
        accum <= accum + 32'(loop_ofs);
      end else begin
        loop_active <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // motion command

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      motion_start <= 1'b0;
      motion_stop <= 1'b0;
      motion_blend <= 1'b0;
      motion_incremental <= 1'b0;
      motion_target <= 32'h00000000;
      current_index <= 8'h00;
    end else begin
      motion_start <= state == seq_pkg::S_LAUNCH;
      motion_stop <= stop_lvl && state != seq_pkg::S_IDLE;
      if (state == seq_pkg::S_LAUNCH) begin
        // absolute shifts the coordinate, incremental the travel amount
        motion_target <= e_pos + (loop_active ? accum : 32'sh00000000);
        motion_incremental <= e_inc;
        motion_blend <= blend_next;
        current_index <= idx;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_end_unlinked;
    done_now && e_link == seq_pkg::LINK_NONE && !stop_lvl && !jump_ok;
  endsequence

  sequence s_timed_end;
    timer_load && !stop_lvl && !jump_ok;
  endsequence

  property p_loop_count;
    loop_active |-> loop_total >= 8'h02 && pass >= 8'h01 && pass <= loop_total;
  endproperty
  a_loop_count: assert property (p_loop_count) else $error("loop count out of range");

  property p_unlinked_halts;
    s_end_unlinked |=> state == seq_pkg::S_IDLE && !sequence_busy_output && ready_output;
  endproperty
  a_unlinked_halts: assert property (p_unlinked_halts) else $error("unlinked entry did not halt");

  property p_wrap;
    // an unlinked loop end halts instead of wrapping, so it is left out here
    done_now && loop_wrap && !halt && !stop_lvl && !jump_ok |=> idx == $past(loop_start)
      && pass == $past(pass) + 8'h01 && accum == $past(accum) + 32'($past(loop_ofs));
  endproperty
  a_wrap: assert property (p_wrap) else $error("loop did not wrap to its start");

  property p_target;
    state == seq_pkg::S_LAUNCH && !stop_lvl |=> motion_start
      && motion_target == $past(e_pos) + ($past(loop_active) ? $past(accum) : 32'sh00000000);
  endproperty
  a_target: assert property (p_target) else $error("target offset wrong");

  property p_step_wait;
    state == seq_pkg::S_STEP && !step_rise && !stop_lvl && !jump_ok
      |=> state == seq_pkg::S_STEP && sequence_busy_output;
  endproperty
  a_step_wait: assert property (p_step_wait) else $error("stepped wait left early");

  property p_stop;
    stop_lvl && state != seq_pkg::S_IDLE |=> !sequence_busy_output ##1 !sequence_busy_output;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not end the sequence");

  property p_no_offset;
    state == seq_pkg::S_LAUNCH && !loop_active |=> motion_target == $past(e_pos);
  endproperty
  a_no_offset: assert property (p_no_offset) else $error("offset outside counted loop");

  property p_timed;
    s_timed_end |=> state == seq_pkg::S_DELAY && sequence_busy_output && !ready_output;
  endproperty
  a_timed: assert property (p_timed) else $error("timed chaining did not wait");

  property p_exit;
    done_now && loop_active && e_end && !loop_wrap && !stop_lvl && !jump_ok |=> !loop_active;
  endproperty
  a_exit: assert property (p_exit) else $error("loop did not end after last pass");
endmodule

// >>> motion_model.sv
/*
  Stand-in for the motion profile generator behind the sequencer: it answers
  every move command with a one-cycle done after a lag chosen by the bench.
  Assumes the sequencer's clock; a stop aborts the move and no done follows.
*/
`timescale 1ns/1ps
module motion_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic motion_start,
  input wire logic motion_stop,
  input wire logic [3:0] lag,
  output logic motion_done
);
  logic moving;
  logic [3:0] left;
  // lag 0 answers two cycles after motion_start, the hardest case for the sequencer
  always_ff @(posedge ref_clk) begin
    motion_done <= 1'b0;
    if (rst || motion_stop) begin
      moving <= 1'b0;
    end else if (motion_start) begin
      moving <= 1'b1;
      left <= lag;
    end else if (moving && left == 4'h0) begin
      moving <= 1'b0;
      motion_done <= 1'b1;
    end else if (moving) begin
      left <= left - 4'h1;
    end
  end
endmodule

// >>> tb.sv
/*
  Self-checking bench of the operation data sequencer: loads entries over the
  register port, starts runs on the host pins and compares every predicted move.
  Assumes the motion model as far side and a 4-cycle millisecond tick.
*/
`timescale 1ns/1ps
module tb;
  logic ref_clk = 0;
  logic rst = 1;
  logic [10:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic [31:0] reg_rdata;
  logic start_input = 0;
  logic stop_input = 0;
  logic sequence_step_input = 0;
  logic [7:0] select_index = 0;
  logic event_jump = 0;
  logic [7:0] event_index = 0;
  logic motion_done, motion_start, motion_stop, motion_blend, motion_incremental;
  logic [31:0] motion_target;
  logic sequence_busy_output, ready_output;
  logic [7:0] current_index;
  logic [3:0] lag = 0;
  int seed = 32'h8b39;
  int fails = 0;
  int comparisons = 0;
  int tn = 0;
  int stops = 0;
  int last_idx = 0;
  logic [31:0] pos_m [256];
  logic [31:0] cfg_m [256];
  logic [22:0] ofs_m [256];
  logic [33:0] exp_q [$];
  logic [33:0] got_q [$];
  logic [31:0] d;

  operation_data_loop_sequencer #(.TICK_CYCLES(4)) dut_u (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .start_input, .stop_input, .sequence_step_input, .select_index, .event_jump,
    .event_index, .motion_done, .motion_start, .motion_stop, .motion_blend, .motion_incremental,
    .motion_target, .sequence_busy_output, .ready_output, .current_index);
  motion_model far_u (.ref_clk, .rst, .motion_start, .motion_stop, .lag, .motion_done);

  initial forever #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (motion_start === 1'b1) got_q.push_back({motion_blend, motion_incremental, motion_target});
  always @(posedge ref_clk) if (motion_stop === 1'b1) stops++;

  //////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [10:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [10:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge ref_clk);
    #1 chk("rdata after", 0, reg_rdata);
  endtask

  function automatic logic [31:0] mk(input logic i, input logic [1:0] l, input logic e, input logic [8:0] n,
    input logic [7:0] c);
    return {11'h000, c, n, e, l, i};
  endfunction

  task automatic put(input logic [7:0] i, input logic [31:0] p, input logic [31:0] c, input logic [22:0] o);
    pos_m[i] = p;
    cfg_m[i] = c;
    ofs_m[i] = o;
    wr({1'b0, i, seq_pkg::FLD_POS}, p);
    wr({1'b0, i, seq_pkg::FLD_CFG}, c);
    wr({1'b0, i, seq_pkg::FLD_OFS}, {9'h000, o});
    wr({1'b0, i, seq_pkg::FLD_DLY}, 32'h00000001);
  endtask

  // walks the shadow table the way the sequencer should
  task automatic predict(input int s, input int lim);
    logic [31:0] c;
    logic [31:0] acc;
    logic act, bl;
    int i, ls, pass, tot;
    exp_q.delete();
    i = s; act = 0; acc = 0; bl = 0; ls = 0; pass = 0; tot = 0;
    while (exp_q.size() < lim && i < 256) begin
      c = cfg_m[i];
      if (!act && c[20:13] >= 8'h02) begin
        act = 1; ls = i; tot = int'(c[20:13]); pass = 1; acc = 0;
      end
      exp_q.push_back({bl, c[0], pos_m[i] + (act ? acc : 32'h0)});
      last_idx = i;
      bl = (c[2:1] == 2'h3);
      if (c[2:1] == 2'h0) break;
      if (act && c[3]) begin
        if (pass < tot) begin
          pass++; acc += {{9{ofs_m[ls][22]}}, ofs_m[ls]}; i = ls;
          continue;
        end
        act = 0;
      end
      if (c[12:4] == 9'h1ff) i = i + 1;
      else if (c[12:4] == 9'h1fe) i = i + 2;
      else if (!c[12]) i = int'(c[11:4]);
      else break;
    end
  endtask

  // how: 0 runs to the end, 1 stops by pin, 2 ends by event jump
  task automatic run(input logic [7:0] s, input int lim, input int how);
    int t, k;
    logic ev, fired, sp;
    predict(s, lim);
    got_q.delete();
    stops = 0;
    k = 0; ev = 0; fired = 0; sp = 0;
    @(posedge ref_clk);
    lag <= 4'($random(seed));
    select_index <= s;
    @(posedge ref_clk);
    start_input <= 1'b1;
    repeat (6) @(posedge ref_clk);
    start_input <= 1'b0;
    for (t = 0; t < 40000; t++) begin
      @(posedge ref_clk);
      sequence_step_input <= (k > 6);
      event_jump <= ev;
      if (sp) stop_input <= 1'b1;
      ev = 0;
      if (k > 0) k--;
      #1;
      if (sequence_busy_output === 1'b1 && ready_output === 1'b1 && k == 0 && how == 0) k = 12;
      if (how != 0 && got_q.size() >= exp_q.size() && !fired) begin
        fired = 1;
        if (how == 1) sp = 1;
        else ev = 1;
      end
      if (sequence_busy_output === 1'b0 && t > 8) break;
    end
    if (t >= 40000) begin
      fails++;
      $display("ERROR wait for idle expected 0 seen 1");
      tally_and_finish();
    end
    chk("busy", 0, sequence_busy_output);
    chk("ready", 1, ready_output);
    if (how != 1) chk("index", how == 2 ? 9 : last_idx, current_index);
    if (how == 2) chk("jump move", {2'b00, pos_m[9]}, got_q[$]);
    chk("moves", 1, how != 0 ? got_q.size() >= exp_q.size() : got_q.size() == exp_q.size());
    foreach (exp_q[j]) if (j < got_q.size()) chk("move", exp_q[j], got_q[j]);
    @(posedge ref_clk);
    stop_input <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rd(seq_pkg::REG_STATUS, d);
    chk("status idle", 0, d[27:24]);
    chk("motion stop", how == 1, stops != 0);
    $display("test %0d done", tn);
    tn++;
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd({1'b0, 8'hc8, seq_pkg::FLD_CFG}, d);
    chk("cfg reset", seq_pkg::CFG_RST, d);
    rd({1'b0, 8'hc8, seq_pkg::FLD_OFS}, d);
    chk("offset reset", 0, d);
    rd(11'h402, d);
    chk("unmapped", 0, d);
    repeat (3) begin
      put(0, $random(seed), mk(0, 3, 0, 9'h1ff, 8'({$random(seed)} % 5 + 2)), 23'($random(seed)));
      put(1, $random(seed), mk(0, 2, 1, 9'h005, 0), 23'($random(seed)));
      put(5, $random(seed), mk(0, 0, 0, 9'h100, 0), 0);
      run(0, 600, 0);
    end
    rd({1'b0, 8'h05, seq_pkg::FLD_CFG}, d);
    chk("cfg back", cfg_m[5], d);
    put(0, 32'd900, mk(1, 1, 0, 9'h1ff, 8'd255), 23'd100);
    put(1, -32'sd900, mk(1, 3, 1, 9'h1fe, 0), -23'sd100);
    put(3, $random(seed), mk(1, 0, 0, 9'h100, 0), 0);
    run(0, 600, 0);
    put(40, $random(seed), mk(0, 2, 0, 9'h1ff, 8'd1), 23'd7);
    put(41, $random(seed), mk(0, 2, 1, 9'h100, 0), 0);
    run(40, 600, 0);
    put(0, $random(seed), mk(0, 0, 0, 9'h1ff, 8'd4), 23'd9);
    put(1, $random(seed), mk(0, 2, 1, 9'h100, 0), 0);
    run(0, 600, 0);
    put(0, $random(seed), mk(0, 2, 0, 9'h1ff, 0), 23'($random(seed)));
    put(1, $random(seed), mk(0, 3, 0, 9'h000, 0), 0);
    put(9, $random(seed), mk(0, 0, 0, 9'h100, 0), 0);
    run(0, 6, 1);
    event_index <= 8'h09;
    run(0, 5, 2);
    tally_and_finish();
  end
endmodule
